// >>> crs_regset.v
`timescale 1ns/10ps
`include "crs_defines.vh"

module crs_regset (
    // Clock and reset
    input wire clock,
    input wire nrst,
    // Mode
    input wire [1:0] addr_mode,
    // Register read port A
    input wire [3:0] rd_a_sel,
    input wire [1:0] rd_a_size,
    // Register read port B
    input wire [3:0] rd_b_sel,
    input wire [1:0] rd_b_size,
    // Register write port
    input wire wr_en,
    input wire [3:0] wr_sel,
    input wire [1:0] wr_size,
    input wire [31:0] wr_data,
    // Stack pointer step
    input wire sp_push,
    input wire sp_pop,
    input wire [1:0] sp_size,
    // Program counter
    input wire reset_vector_load,
    input wire [23:0] reset_vector,
    input wire pc_load,
    input wire [23:0] pc_next,
    // Memory access address
    input wire [23:0] ea_in,
    input wire [1:0] ea_size,
    // Flag updates from the executor
    input wire [1:0] flag_op,
    input wire [31:0] alu_a,
    input wire [31:0] alu_b,
    input wire [31:0] alu_result,
    input wire alu_sub,
    input wire [1:0] alu_size,
    input wire shift_carry,
    input wire bit_carry_wr,
    input wire bit_carry,
    input wire [7:0] bcd_in,
    // Control register operations
    input wire [2:0] ctl_op,
    input wire [7:0] ctl_data,
    input wire exc_start,
    // Interrupt request
    input wire irq,
    input wire nmi,
    // Outputs
    output reg [31:0] rd_a_data,
    output reg [31:0] rd_b_data,
    output reg [31:0] stack_pointer,
    output reg [23:0] program_counter,
    output reg [23:0] fetch_addr,
    output reg [23:0] mem_addr,
    output reg [7:0] condition_flags,
    output reg int_accept,
    output reg [3:0] branch_flags,
    output reg bcd_digits_valid
);
    reg [31:0] wide_gp_regs [0:7];
    reg [23:0] next_pc;
    reg [23:0] amask;
    reg [7:0] next_flags;
    reg [31:0] sp_step;
    reg [23:0] next_fetch_addr;
    reg [23:0] next_mem_addr;
    reg next_int_accept;
    reg next_bcd_valid;
    reg int_masked;
    reg ctl_hit;
    reg [7:0] ctl_result;
    reg [7:0] alu_flags;
    wire [1:0] digit_ok;
    wire fc_h;
    wire fc_n;
    wire fc_z;
    wire fc_v;
    wire fc_c;
    genvar gi;
    genvar gd;

    crs_flag_calc u_flag_calc (
        .op_a(alu_a),
        .op_b(alu_b),
        .result(alu_result),
        .size(alu_size),
        .subtract(alu_sub),
        .half_carry(fc_h),
        .negative(fc_n),
        .zero(fc_z),
        .overflow(fc_v),
        .carry(fc_c)
    );

    // View read: sel[3] picks extended half or high byte
    function [31:0] view_rd;
        input [31:0] r;
        input [1:0] sz;
        input hi;
        begin
            case (sz)
                `CRS_SZ_BYTE:
                    view_rd = {24'h000000, hi ? r[15:8] : r[7:0]};
                `CRS_SZ_WORD:
                    view_rd = {16'h0000, hi ? r[31:16] : r[15:0]};
                default:
                    view_rd = r;
            endcase
        end
    endfunction

    function [31:0] view_wr;
        input [31:0] r;
        input [1:0] sz;
        input hi;
        input [31:0] d;
        begin
            // Untouched bits of the containing register kept
            case (sz)
                `CRS_SZ_BYTE:
                    view_wr = hi ? {r[31:16], d[7:0], r[7:0]}
                                 : {r[31:8], d[7:0]};
                `CRS_SZ_WORD:
                    view_wr = hi ? {d[15:0], r[15:0]}
                                 : {r[31:16], d[15:0]};
                default:
                    view_wr = d;
            endcase
        end
    endfunction

    always @*
    begin
        case (sp_size)
            `CRS_SZ_LONG:
                sp_step = 32'h00000004;
            `CRS_SZ_WORD:
                sp_step = 32'h00000002;
            default:
                sp_step = 32'h00000002; // Byte steps move by a word
        endcase
    end

    // General registers carry no reset value
    generate
        for (gi = 0; gi < 8; gi = gi + 1)
        begin : g_reg
            reg [31:0] next_gp;

            // Stack steps win over a view write to the stack register
            always @*
            begin
                next_gp = wide_gp_regs[gi];
                if (gi == `CRS_SP_NUM && sp_push)
                    next_gp = wide_gp_regs[gi] - sp_step;
                else if (gi == `CRS_SP_NUM && sp_pop)
                    next_gp = wide_gp_regs[gi] + sp_step;
                else if (wr_en && wr_sel[2:0] == gi)
                    next_gp = view_wr(wide_gp_regs[gi], wr_size, wr_sel[3], wr_data);
            end

            always @(posedge clock)
            begin
                wide_gp_regs[gi] <= next_gp;
            end
        end
    endgenerate

    always @(posedge clock)
    begin
        rd_a_data <= view_rd(wide_gp_regs[rd_a_sel[2:0]], rd_a_size, rd_a_sel[3]);
        rd_b_data <= view_rd(wide_gp_regs[rd_b_sel[2:0]], rd_b_size, rd_b_sel[3]);
        stack_pointer <= wide_gp_regs[`CRS_SP_NUM];
    end

    // Address mask per mode
    always @*
    begin
        case (addr_mode)
            `CRS_AMODE_NORMAL:
                amask = `CRS_NORMAL_MASK;
            `CRS_AMODE_MB1:
                amask = `CRS_MB1_MASK;
            `CRS_AMODE_ADV:
                amask = `CRS_ADV_MASK;
            default:
                amask = `CRS_ADV_MASK; // Unused code acts as advanced
        endcase
    end

    always @*
    begin
        next_pc = program_counter;
        if (reset_vector_load)
            next_pc = reset_vector;
        else if (pc_load)
            next_pc = pc_next;
    end

    // Fetch ignores bit 0; wide data aligns down without an error
    always @*
    begin
        next_fetch_addr = {next_pc[23:1], 1'b0} & amask;
        next_mem_addr = ea_in & amask;
        if (ea_size != `CRS_SZ_BYTE)
            next_mem_addr[0] = 1'b0;
    end

    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            program_counter <= 24'h000000;
            fetch_addr <= 24'h000000;
            mem_addr <= 24'h000000;
        end
        else
        begin
            program_counter <= next_pc & amask;
            fetch_addr <= next_fetch_addr;
            mem_addr <= next_mem_addr;
        end
    end

    // Control register operation result
    always @*
    begin
        ctl_hit = 1'b1;
        ctl_result = condition_flags;
        case (ctl_op)
            `CRS_COP_LOAD:
                ctl_result = ctl_data;
            `CRS_COP_AND:
                ctl_result = condition_flags & ctl_data;
            `CRS_COP_OR:
                ctl_result = condition_flags | ctl_data;
            `CRS_COP_XOR:
                ctl_result = condition_flags ^ ctl_data;
            default:
                ctl_hit = 1'b0;
        endcase
    end

    // Executor flag update
    always @*
    begin
        alu_flags = condition_flags;
        case (flag_op)
            `CRS_FL_ARITH:
            begin
                alu_flags[`CRS_CF_H] = fc_h;
                alu_flags[`CRS_CF_N] = fc_n;
                alu_flags[`CRS_CF_Z] = fc_z;
                alu_flags[`CRS_CF_V] = fc_v;
                alu_flags[`CRS_CF_C] = fc_c;
            end
            `CRS_FL_LOGIC:
            begin
                alu_flags[`CRS_CF_N] = fc_n;
                alu_flags[`CRS_CF_Z] = fc_z;
                alu_flags[`CRS_CF_V] = 1'b0;
            end
            `CRS_FL_CARRY:
                alu_flags[`CRS_CF_C] = shift_carry;
            default:
                alu_flags = condition_flags;
        endcase
    end

    // Control operations win over executor flags
    // Bit accumulator and exception mask are applied last
    always @*
    begin
        next_flags = ctl_hit ? ctl_result : alu_flags;
        if (bit_carry_wr)
            next_flags[`CRS_CF_C] = bit_carry;
        if (exc_start)
            next_flags[`CRS_CF_I] = 1'b1;
    end

    // User bit 6 may serve as extra mask
    always @*
    begin
        int_masked = next_flags[`CRS_CF_I] | next_flags[`CRS_CF_UI];
        next_int_accept = nmi | (irq & ~int_masked);
        next_bcd_valid = &digit_ok;
    end

    // Each nibble of the decimal byte must be a digit
    generate
        for (gd = 0; gd < 2; gd = gd + 1)
        begin : g_digit
            assign digit_ok[gd] = (bcd_in[gd * 4 +: 4] < 4'ha);
        end
    endgenerate

    // Only the mask bit is set at reset; others come up as the default
    always @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            condition_flags <= `CRS_CF_RESET;
            int_accept <= 1'b0;
            branch_flags <= 4'h0;
            bcd_digits_valid <= 1'b0;
        end
        else
        begin
            condition_flags <= next_flags;
            int_accept <= next_int_accept;
            branch_flags <= next_flags[3:0];
            bcd_digits_valid <= next_bcd_valid;
        end
    end
endmodule // crs_regset

// >>> crs_defines.vh
`ifndef CRS_DEFINES_VH
`define CRS_DEFINES_VH

// Address space widths
`define CRS_NORMAL_AW 16
`define CRS_ADV_AW 24
`define CRS_MB1_AW 20
`define CRS_NORMAL_MASK 24'h00ffff
`define CRS_MB1_MASK 24'h0fffff
`define CRS_ADV_MASK 24'hffffff

// Address modes
`define CRS_AMODE_NORMAL 2'h0
`define CRS_AMODE_ADV 2'h1
`define CRS_AMODE_MB1 2'h2

// Register view sizes
`define CRS_SZ_BYTE 2'h0
`define CRS_SZ_WORD 2'h1
`define CRS_SZ_LONG 2'h2

// Condition flag bit positions
`define CRS_CF_I 7
`define CRS_CF_UI 6
`define CRS_CF_H 5
`define CRS_CF_U 4
`define CRS_CF_N 3
`define CRS_CF_Z 2
`define CRS_CF_V 1
`define CRS_CF_C 0
`define CRS_CF_RESET 8'h80

// Control register operations
`define CRS_COP_NONE 3'h0
`define CRS_COP_LOAD 3'h1
`define CRS_COP_AND 3'h2
`define CRS_COP_OR 3'h3
`define CRS_COP_XOR 3'h4

// Stack pointer register number
`define CRS_SP_NUM 3'h7

// Flag update select from the executor
`define CRS_FL_KEEP 2'h0
`define CRS_FL_ARITH 2'h1
`define CRS_FL_LOGIC 2'h2
`define CRS_FL_CARRY 2'h3

// Instruction type count
`define CRS_INSN_TYPES 62

`endif

// >>> crs_flag_calc.v
`timescale 1ns/10ps
`include "crs_defines.vh"

module crs_flag_calc (
    // Operands and result
    input wire [31:0] op_a,
    input wire [31:0] op_b,
    input wire [31:0] result,
    input wire [1:0] size,
    input wire subtract,
    // Flags out
    output reg half_carry,
    output reg negative,
    output reg zero,
    output reg overflow,
    output reg carry
);
    reg [32:0] sum33;
    reg [31:0] b_eff;
    reg sa;
    reg sb;
    reg sr;

    always @*
    begin
        b_eff = subtract ? ~op_b : op_b;
        sum33 = 33'h0;
        sa = 1'b0;
        sb = 1'b0;
        sr = 1'b0;
        half_carry = 1'b0;
        carry = 1'b0;
        negative = 1'b0;
        zero = 1'b0;
        case (size)
            `CRS_SZ_BYTE:
            begin
                // Carry or borrow out of bit 3
                half_carry = op_a[4] ^ op_b[4] ^ result[4];
                // Subtract is a plus inverted b plus one; equal operands give no borrow
                sum33 = {25'h0, op_a[7:0]} + {25'h0, b_eff[7:0]} + {32'h0, subtract};
                carry = sum33[8] ^ subtract;
                sa = op_a[7];
                sb = op_b[7];
                sr = result[7];
                zero = (result[7:0] == 8'h00);
            end
            `CRS_SZ_WORD:
            begin
                half_carry = op_a[12] ^ op_b[12] ^ result[12];
                sum33 = {17'h0, op_a[15:0]} + {17'h0, b_eff[15:0]} + {32'h0, subtract};
                carry = sum33[16] ^ subtract;
                sa = op_a[15];
                sb = op_b[15];
                sr = result[15];
                zero = (result[15:0] == 16'h0000);
            end
            default:
            begin
                half_carry = op_a[28] ^ op_b[28] ^ result[28];
                sum33 = {1'b0, op_a} + {1'b0, b_eff} + {32'h0, subtract};
                carry = sum33[32] ^ subtract;
                sa = op_a[31];
                sb = op_b[31];
                sr = result[31];
                zero = (result == 32'h00000000);
            end
        endcase
        negative = sr;
        overflow = (sa ^ sr) & (subtract ? (sa ^ sb) : ~(sa ^ sb));
    end
endmodule // crs_flag_calc

// >>> crs_alu_model.sv
`timescale 1ns/10ps
module crs_alu_model (
    // Operands
    input wire [31:0] alu_a,
    input wire [31:0] alu_b,
    input wire alu_sub,
    // Result
    output wire [31:0] alu_result
);
    // Full width, so carries above the operand size stay visible
    assign alu_result = alu_sub ? alu_a - alu_b : alu_a + alu_b;
endmodule // crs_alu_model

// >>> crs_regset_props.sv
`timescale 1ns/10ps
module crs_regset_props (
    // Clock and reset
    input wire clock,
    input wire nrst,
    // Watched inputs
    input wire [1:0] addr_mode,
    input wire [23:0] ea_in,
    input wire [1:0] ea_size,
    input wire [2:0] ctl_op,
    input wire [7:0] ctl_data,
    input wire exc_start,
    input wire bit_carry_wr,
    input wire irq,
    input wire nmi,
    // Watched outputs
    input wire [23:0] fetch_addr,
    input wire [23:0] mem_addr,
    input wire [7:0] condition_flags,
    input wire [3:0] branch_flags,
    input wire int_accept
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);
    normal_mask_a: assert property (
        addr_mode == 2'h0 |=> mem_addr[23:16] == 8'h00) else $error("normal mode address high");
    adv_pass_a: assert property (
        addr_mode[0] && ea_size == 2'h0 |=> mem_addr == $past(ea_in)) else $error("advanced addr");
    mb1_trunc_a: assert property (
        addr_mode == 2'h2 |=> mem_addr[23:20] == 4'h0 && mem_addr[19:1] == $past(ea_in[19:1]))
        else $error("1-Mbyte address wrong");
    even_access_a: assert property (
        ea_size != 2'h0 |=> !mem_addr[0]) else $error("odd wide access");
    fetch_even_a: assert property (fetch_addr[0] == 1'b0) else $error("odd fetch");
    exc_mask_a: assert property (
        exc_start |=> condition_flags[7]) else $error("mask not set on exception");
    flag_load_a: assert property (
        ctl_op == 3'h1 && !exc_start && !bit_carry_wr |=> condition_flags == $past(ctl_data))
        else $error("flag load wrong");
    flag_xor_a: assert property (
        ctl_op == 3'h4 && !exc_start && !bit_carry_wr
        |=> condition_flags == ($past(condition_flags) ^ $past(ctl_data))) else $error("xor");
    branch_copy_a: assert property (
        branch_flags == condition_flags[3:0]) else $error("branch flags differ");
    int_gate_a: assert property (
        int_accept == ($past(nmi) | $past(irq) & !condition_flags[7] & !condition_flags[6]))
        else $error("interrupt acceptance wrong");
    cover property (exc_start);
    cover property (int_accept && !nmi);
    cover property (addr_mode == 2'h2 && ea_size != 2'h0);
endmodule // crs_regset_props

bind crs_regset crs_regset_props u_props (.clock, .nrst, .addr_mode, .ea_in, .ea_size, .ctl_op,
    .ctl_data, .exc_start, .bit_carry_wr, .irq, .nmi, .fetch_addr, .mem_addr, .condition_flags,
    .branch_flags, .int_accept);

// >>> crs_regset_tb.sv
`timescale 1ns/10ps
`include "crs_defines.vh"
module crs_regset_tb;
    logic clock = 1'b0;
    logic nrst, wr_en, sp_push, sp_pop, reset_vector_load, pc_load, alu_sub, shift_carry;
    logic bit_carry_wr, bit_carry, exc_start, irq, nmi, int_accept, bcd_digits_valid;
    logic [1:0] addr_mode, rd_a_size, rd_b_size, wr_size, sp_size, ea_size, flag_op, alu_size;
    logic [3:0] rd_a_sel, rd_b_sel, wr_sel, branch_flags;
    logic [31:0] wr_data, alu_a, alu_b, alu_result, rd_a_data, rd_b_data, stack_pointer;
    logic [23:0] reset_vector, pc_next, ea_in, program_counter, fetch_addr, mem_addr;
    logic [7:0] bcd_in, ctl_data, condition_flags;
    logic [2:0] ctl_op;
    int fail_count = 0;
    int n_tests = 0;

    crs_regset uut (.clock, .nrst, .addr_mode, .rd_a_sel, .rd_a_size, .rd_b_sel, .rd_b_size,
        .wr_en, .wr_sel, .wr_size, .wr_data, .sp_push, .sp_pop, .sp_size, .reset_vector_load,
        .reset_vector, .pc_load, .pc_next, .ea_in, .ea_size, .flag_op, .alu_a, .alu_b,
        .alu_result, .alu_sub, .alu_size, .shift_carry, .bit_carry_wr, .bit_carry, .bcd_in,
        .ctl_op, .ctl_data, .exc_start, .irq, .nmi, .rd_a_data, .rd_b_data, .stack_pointer,
        .program_counter, .fetch_addr, .mem_addr, .condition_flags, .int_accept,
        .branch_flags, .bcd_digits_valid);
    crs_alu_model alu (.alu_a, .alu_b, .alu_sub, .alu_result);

    always #50 clock = ~clock;

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Pulses are lowered after one edge; an idle edge follows
    task automatic tick;
        @(negedge clock);
        {wr_en, sp_push, sp_pop, reset_vector_load, pc_load, bit_carry_wr, exc_start} = '0;
        {flag_op, ctl_op} = '0;
        @(negedge clock);
    endtask

    task automatic wr(input logic [3:0] sel, input logic [1:0] sz, input logic [31:0] d);
        {wr_sel, wr_size, wr_data, wr_en} = {sel, sz, d, 1'b1};
        tick;
    endtask

    task automatic rd(input logic [3:0] sel, input logic [1:0] sz, input logic [31:0] exp);
        {rd_a_sel, rd_a_size, rd_b_sel, rd_b_size} = {sel, sz, sel, sz};
        tick;
        chk(rd_a_data, exp);
        chk(rd_b_data, exp);
    endtask

    task automatic sp(input logic push, input logic pop, input logic [1:0] sz,
        input logic [31:0] exp);
        {sp_push, sp_pop, sp_size} = {push, pop, sz};
        tick;
        chk(stack_pointer, exp);
    endtask

    task automatic fl(input logic [1:0] op, input logic [31:0] a, input logic [31:0] b,
        input logic sub, input logic [1:0] sz, input logic [7:0] exp);
        {flag_op, alu_a, alu_b, alu_sub, alu_size} = {op, a, b, sub, sz};
        tick;
        chk(condition_flags, exp);
        chk(branch_flags, exp[3:0]);
    endtask

    task automatic ctl(input logic [2:0] op, input logic [7:0] d, input logic [7:0] exp);
        {ctl_op, ctl_data} = {op, d};
        tick;
        chk(condition_flags, exp);
    endtask

    initial
    begin
        repeat (3000) @(posedge clock);
        fail_count++;
        give_verdict;
    end

    initial
    begin
        {nrst, wr_en, sp_push, sp_pop, reset_vector_load, pc_load, alu_sub, shift_carry} = '0;
        {bit_carry_wr, bit_carry, exc_start, irq, nmi, addr_mode, rd_a_size, rd_b_size} = '0;
        {wr_size, sp_size, ea_size, flag_op, alu_size, rd_a_sel, rd_b_sel, wr_sel} = '0;
        {wr_data, alu_a, alu_b, reset_vector, pc_next, ea_in, bcd_in, ctl_data, ctl_op} = '0;
        repeat (8) @(negedge clock);
        nrst = 1'b1;
        chk(condition_flags, 8'h80);
        {reset_vector_load, reset_vector} = {1'b1, 24'h000101};
        tick;
        chk(program_counter, 24'h000101);
        chk(fetch_addr, 24'h000100);
        {pc_load, pc_next} = {1'b1, 24'habcdef};
        tick;
        chk(fetch_addr, 24'h00cdee);
        chk(program_counter, 24'h00cdef);
        for (int i = 0; i < 8; i++)
            wr({1'b0, i[2:0]}, `CRS_SZ_LONG, {8{i[3:0]}});
        for (int i = 0; i < 8; i++)
            rd({1'b0, i[2:0]}, `CRS_SZ_LONG, {8{i[3:0]}});
        {rd_a_sel, rd_b_sel} = {4'h1, 4'h6};
        tick;
        chk(rd_a_data, 32'h11111111);
        chk(rd_b_data, 32'h66666666);
        wr(4'hb, `CRS_SZ_WORD, 32'hbeef);
        wr(4'h3, `CRS_SZ_BYTE, 32'h5a);
        rd(4'h3, `CRS_SZ_LONG, 32'hbeef335a);
        rd(4'h3, `CRS_SZ_WORD, 32'h335a);
        rd(4'hb, `CRS_SZ_BYTE, 32'h33);
        wr(4'h7, `CRS_SZ_LONG, 32'h1000);
        sp(1'b1, 1'b0, `CRS_SZ_LONG, 32'h0ffc);
        sp(1'b1, 1'b0, `CRS_SZ_WORD, 32'h0ffa);
        sp(1'b0, 1'b1, `CRS_SZ_LONG, 32'h0ffe);
        {wr_en, wr_sel, wr_size, wr_data} = {1'b1, 4'h7, `CRS_SZ_LONG, 32'h0};
        sp(1'b0, 1'b1, `CRS_SZ_WORD, 32'h1000);
        ea_in = 24'hfedcb7;
        for (int m = 0; m < 4; m++)
            for (int s = 0; s < 3; s++)
            begin
                {addr_mode, ea_size} = {m[1:0], s[1:0]};
                tick;
                chk(mem_addr, (m == 0 ? 24'h00dcb7 : m == 2 ? 24'h0edcb7 : 24'hfedcb7)
                    & ~{23'h0, s != 0});
            end
        ctl(`CRS_COP_LOAD, 8'h80, 8'h80);
        fl(`CRS_FL_ARITH, 32'h0f, 32'h01, 1'b0, `CRS_SZ_BYTE, 8'ha0);
        fl(`CRS_FL_ARITH, 32'h80, 32'h80, 1'b0, `CRS_SZ_BYTE, 8'h87);
        fl(`CRS_FL_ARITH, 32'h7f, 32'h01, 1'b0, `CRS_SZ_BYTE, 8'haa);
        fl(`CRS_FL_ARITH, 32'h10, 32'h01, 1'b1, `CRS_SZ_BYTE, 8'ha0);
        fl(`CRS_FL_ARITH, 32'h00, 32'h01, 1'b1, `CRS_SZ_BYTE, 8'ha9);
        fl(`CRS_FL_ARITH, 32'h05, 32'h05, 1'b1, `CRS_SZ_BYTE, 8'h84);
        fl(`CRS_FL_ARITH, 32'h0800, 32'h0800, 1'b0, `CRS_SZ_WORD, 8'ha0);
        fl(`CRS_FL_ARITH, 32'h08000000, 32'h08000000, 1'b0, `CRS_SZ_LONG, 8'ha0);
        fl(`CRS_FL_LOGIC, 32'h0, 32'h0, 1'b0, `CRS_SZ_LONG, 8'ha4);
        fl(`CRS_FL_KEEP, 32'h80, 32'h80, 1'b0, `CRS_SZ_BYTE, 8'ha4);
        shift_carry = 1'b1;
        fl(`CRS_FL_CARRY, 32'h0, 32'h0, 1'b0, `CRS_SZ_BYTE, 8'ha5);
        bit_carry_wr = 1'b1;
        fl(`CRS_FL_KEEP, 32'h0, 32'h0, 1'b0, `CRS_SZ_BYTE, 8'ha4);
        ctl(`CRS_COP_LOAD, 8'h55, 8'h55);
        ctl(`CRS_COP_AND, 8'h0f, 8'h05);
        ctl(`CRS_COP_OR, 8'h50, 8'h55);
        ctl(`CRS_COP_XOR, 8'hff, 8'haa);
        irq = 1'b1;
        ctl(`CRS_COP_LOAD, 8'h00, 8'h00);
        chk(int_accept, 1'b1);
        exc_start = 1'b1;
        tick;
        chk(condition_flags, 8'h80);
        chk(int_accept, 1'b0);
        ctl(`CRS_COP_LOAD, 8'h40, 8'h40);
        chk(int_accept, 1'b0);
        nmi = 1'b1;
        ctl(`CRS_COP_LOAD, 8'hc0, 8'hc0);
        chk(int_accept, 1'b1);
        bcd_in = 8'h59;
        tick;
        chk(bcd_digits_valid, 1'b1);
        bcd_in = 8'h5a;
        tick;
        chk(bcd_digits_valid, 1'b0);
        give_verdict;
    end
endmodule // crs_regset_tb
